// ==== core/tpg_pkg.sv ====
// Package for the twelve pin configuration block.
// Assumes an APB3 master and 12-bit byte addresses.
package tpg_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NPINS = 12;
	localparam int LOW_PINS = 4;
	localparam int HIGH_PINS = 8;
	localparam int ADDR_W = 12;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] GPIO_LOW_CONFIG_ADDR = 12'h018;
	localparam logic [ADDR_W-1:0] GPIO_HIGH_CONFIG_ADDR = 12'h01C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int LOW_DAT_LSB = 0;
	localparam int LOW_DIR_LSB = 4;
	localparam int LOW_DRV_LSB = 8;
	localparam int LOW_FSEL_LSB = 12;
	localparam int HIGH_DAT_LSB = 0;
	localparam int HIGH_DIR_LSB = 8;
	localparam int HIGH_DRV_LSB = 16;
	localparam int HIGH_FSEL_LSB = 24;

	// ----------------------------------------------------------------
	// Configuration image
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NPINS-1:0] pin_function_select;
		logic [NPINS-1:0] output_drive_type;
		logic [NPINS-1:0] pin_direction;
		logic [NPINS-1:0] pin_level_value;
	} tpg_cfg_t;

	// Fallback values when no image source exists
	localparam logic [LOW_PINS-1:0] FSEL_FALLBACK_LOW = 4'hF;
	localparam logic [HIGH_PINS-1:0] FSEL_FALLBACK_HIGH = 8'hFF;
	localparam logic [NPINS-1:0] FIELD_FALLBACK_ZERO = 12'h000;
	localparam tpg_cfg_t CFG_FALLBACK = '{
		pin_function_select: {FSEL_FALLBACK_HIGH, FSEL_FALLBACK_LOW},
		output_drive_type: FIELD_FALLBACK_ZERO,
		pin_direction: FIELD_FALLBACK_ZERO,
		pin_level_value: FIELD_FALLBACK_ZERO
	};

	// ----------------------------------------------------------------
	// APB request and answer
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} tpg_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} tpg_apb_rsp_t;
endpackage : tpg_pkg

// ==== core/tpg_sync.sv ====
// Two-stage synchroniser for the pin levels.
// Assumes asynchronous inputs and a single pclk domain.
`timescale 1ns/1ps
module tpg_sync #(
	parameter int WIDTH = 12,
	parameter int STAGES = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (STAGES < 2) begin : g_bad_stages
		$error("tpg_sync needs at least two stages");
	end

	// ----------------------------------------------------------------
	// Chain
	// ----------------------------------------------------------------
	logic [STAGES-1:0][WIDTH-1:0] chain_r;
	logic [STAGES-1:0][WIDTH-1:0] chain_nxt;

	always_comb begin
		chain_nxt = {chain_r[STAGES-2:0], async_in};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chain_r <= '0;
		end else begin
			chain_r <= chain_nxt;
		end
	end

	assign sync_out = chain_r[STAGES-1];
endmodule : tpg_sync

// ==== core/tpg_gpio.sv ====
// Twelve pin configuration and data block with APB register access.
// Assumes an APB3 master on pclk and a loader that strobes image_load.
`timescale 1ns/1ps
module tpg_gpio #(
	parameter int SYNC_STAGES = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire tpg_pkg::tpg_apb_req_t apb_req,
	output tpg_pkg::tpg_apb_rsp_t apb_rsp,
	input wire logic image_load,
	input wire logic eeprom_present,
	input wire logic otp_programmed,
	input wire tpg_pkg::tpg_cfg_t eeprom_image,
	input wire tpg_pkg::tpg_cfg_t otp_image,
	input wire logic usb_reset,
	input wire logic lite_soft_reset,
	input wire logic reset_protect,
	input wire logic [tpg_pkg::NPINS-1:0] wake_enable,
	input wire logic [tpg_pkg::NPINS-1:0] wake_polarity,
	input wire logic [tpg_pkg::NPINS-1:0] alt_out,
	input wire logic [tpg_pkg::NPINS-1:0] alt_oe,
	input wire logic [tpg_pkg::NPINS-1:0] pin_in,
	output logic [tpg_pkg::NPINS-1:0] pin_out,
	output logic [tpg_pkg::NPINS-1:0] pin_oe,
	output logic [tpg_pkg::NPINS-1:0] wake_event
);
	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (SYNC_STAGES < 2) begin : g_bad_sync
		$error("tpg_gpio needs at least two sync stages");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		tpg_pkg::tpg_cfg_t cfg;
		tpg_pkg::tpg_cfg_t img;
		tpg_pkg::tpg_apb_rsp_t rsp;
		logic [tpg_pkg::NPINS-1:0] pin_out;
		logic [tpg_pkg::NPINS-1:0] pin_oe;
		logic [tpg_pkg::NPINS-1:0] wake;
	} tpg_state_t;

	tpg_state_t st_r;
	tpg_state_t st_nxt;
	logic [tpg_pkg::NPINS-1:0] pin_sync;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	tpg_sync #(
		.WIDTH(tpg_pkg::NPINS),
		.STAGES(SYNC_STAGES)
	) tpg_sync_i (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ----------------------------------------------------------------
	// Register packing
	// ----------------------------------------------------------------
	function automatic logic [31:0] tpg_pack_low(input tpg_pkg::tpg_cfg_t c,
		input logic [tpg_pkg::NPINS-1:0] lvl);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[tpg_pkg::LOW_FSEL_LSB +: tpg_pkg::LOW_PINS] =
			c.pin_function_select[tpg_pkg::LOW_PINS-1:0];
		w[tpg_pkg::LOW_DRV_LSB +: tpg_pkg::LOW_PINS] =
			c.output_drive_type[tpg_pkg::LOW_PINS-1:0];
		w[tpg_pkg::LOW_DIR_LSB +: tpg_pkg::LOW_PINS] =
			c.pin_direction[tpg_pkg::LOW_PINS-1:0];
		w[tpg_pkg::LOW_DAT_LSB +: tpg_pkg::LOW_PINS] =
			lvl[tpg_pkg::LOW_PINS-1:0];
		return w;
	endfunction : tpg_pack_low

	function automatic logic [31:0] tpg_pack_high(input tpg_pkg::tpg_cfg_t c,
		input logic [tpg_pkg::NPINS-1:0] lvl);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[tpg_pkg::HIGH_FSEL_LSB +: tpg_pkg::HIGH_PINS] =
			c.pin_function_select[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS];
		w[tpg_pkg::HIGH_DRV_LSB +: tpg_pkg::HIGH_PINS] =
			c.output_drive_type[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS];
		w[tpg_pkg::HIGH_DIR_LSB +: tpg_pkg::HIGH_PINS] =
			c.pin_direction[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS];
		w[tpg_pkg::HIGH_DAT_LSB +: tpg_pkg::HIGH_PINS] =
			lvl[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS];
		return w;
	endfunction : tpg_pack_high

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic setup_ph;
	logic acc_done;
	logic hit_low;
	logic hit_high;
	logic wr_low;
	logic wr_high;
	logic restore;

	assign setup_ph = apb_req.psel && !apb_req.penable;
	assign acc_done = apb_req.psel && apb_req.penable && st_r.rsp.pready;
	assign hit_low = apb_req.paddr == tpg_pkg::GPIO_LOW_CONFIG_ADDR;
	assign hit_high = apb_req.paddr == tpg_pkg::GPIO_HIGH_CONFIG_ADDR;
	assign wr_low = acc_done && apb_req.pwrite && hit_low;
	assign wr_high = acc_done && apb_req.pwrite && hit_high;
	assign restore = (usb_reset || lite_soft_reset) && !reset_protect;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// Answer in the first access cycle
		st_nxt.rsp.pready = setup_ph;
		st_nxt.rsp.pslverr = setup_ph && !hit_low && !hit_high;
		if (setup_ph && !apb_req.pwrite) begin
			st_nxt.rsp.prdata = hit_low ? tpg_pack_low(st_r.cfg, pin_sync) :
				hit_high ? tpg_pack_high(st_r.cfg, pin_sync) : 32'h0000_0000;
		end else if (!setup_ph) begin
			st_nxt.rsp.prdata = 32'h0000_0000;
		end
		// Low register write, bits 31:16 dropped
		if (wr_low) begin
			st_nxt.cfg.pin_function_select[tpg_pkg::LOW_PINS-1:0] =
				apb_req.pwdata[tpg_pkg::LOW_FSEL_LSB +: tpg_pkg::LOW_PINS];
			st_nxt.cfg.output_drive_type[tpg_pkg::LOW_PINS-1:0] =
				apb_req.pwdata[tpg_pkg::LOW_DRV_LSB +: tpg_pkg::LOW_PINS];
			st_nxt.cfg.pin_direction[tpg_pkg::LOW_PINS-1:0] =
				apb_req.pwdata[tpg_pkg::LOW_DIR_LSB +: tpg_pkg::LOW_PINS];
			st_nxt.cfg.pin_level_value[tpg_pkg::LOW_PINS-1:0] =
				apb_req.pwdata[tpg_pkg::LOW_DAT_LSB +: tpg_pkg::LOW_PINS];
		end
		// High register write
		if (wr_high) begin
			st_nxt.cfg.pin_function_select[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS] =
				apb_req.pwdata[tpg_pkg::HIGH_FSEL_LSB +: tpg_pkg::HIGH_PINS];
			st_nxt.cfg.output_drive_type[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS] =
				apb_req.pwdata[tpg_pkg::HIGH_DRV_LSB +: tpg_pkg::HIGH_PINS];
			st_nxt.cfg.pin_direction[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS] =
				apb_req.pwdata[tpg_pkg::HIGH_DIR_LSB +: tpg_pkg::HIGH_PINS];
			st_nxt.cfg.pin_level_value[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS] =
				apb_req.pwdata[tpg_pkg::HIGH_DAT_LSB +: tpg_pkg::HIGH_PINS];
		end
		// Image load, overrides writes in the same cycle unless reset_protect is set
		if (image_load) begin
			if (eeprom_present) begin
				st_nxt.img = eeprom_image;
			end else if (otp_programmed) begin
				st_nxt.img = otp_image;
			end else begin
				st_nxt.img = tpg_pkg::CFG_FALLBACK;
			end
			if (!reset_protect) begin
				st_nxt.cfg = st_nxt.img;
			end
		end else if (restore) begin
			st_nxt.cfg = st_r.img;
		end
		// Pin drivers
		for (int i = 0; i < tpg_pkg::NPINS; i++) begin
			if (st_r.cfg.pin_function_select[i]) begin
				st_nxt.pin_oe[i] = alt_oe[i];
				st_nxt.pin_out[i] = alt_out[i];
			end else if (!st_r.cfg.pin_direction[i]) begin
				st_nxt.pin_oe[i] = 1'b0;
				st_nxt.pin_out[i] = 1'b0;
			end else if (st_r.cfg.output_drive_type[i]) begin
				st_nxt.pin_oe[i] = 1'b1;
				st_nxt.pin_out[i] = st_r.cfg.pin_level_value[i];
			end else begin
				st_nxt.pin_oe[i] = !st_r.cfg.pin_level_value[i];
				st_nxt.pin_out[i] = 1'b0;
			end
			st_nxt.wake[i] = !st_r.cfg.pin_function_select[i] &&
				!st_r.cfg.pin_direction[i] &&
				wake_enable[i] && (pin_sync[i] == wake_polarity[i]);
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.cfg <= tpg_pkg::CFG_FALLBACK;
			st_r.img <= tpg_pkg::CFG_FALLBACK;
			st_r.rsp <= '0;
			st_r.pin_out <= '0;
			st_r.pin_oe <= '0;
			st_r.wake <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign apb_rsp = st_r.rsp;
	assign pin_out = st_r.pin_out;
	assign pin_oe = st_r.pin_oe;
	assign wake_event = st_r.wake;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_low_write;
		wr_low && !image_load && !restore |=>
			st_r.cfg.pin_direction[tpg_pkg::LOW_PINS-1:0] ==
			$past(apb_req.pwdata[tpg_pkg::LOW_DIR_LSB +: tpg_pkg::LOW_PINS]);
	endproperty
	a_low_write: assert property (p_low_write) else $error("low direction not written");

	property p_high_fsel;
		wr_high && !image_load && !restore |=>
			st_r.cfg.pin_function_select[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS] ==
			$past(apb_req.pwdata[tpg_pkg::HIGH_FSEL_LSB +: tpg_pkg::HIGH_PINS]);
	endproperty
	a_high_fsel: assert property (p_high_fsel) else $error("high select not written");

	property p_reserved;
		setup_ph && !apb_req.pwrite && hit_low |=> st_r.rsp.prdata[31:16] == 16'h0000;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

	property p_read_level;
		setup_ph && !apb_req.pwrite && hit_high |=>
			st_r.rsp.pready && st_r.rsp.prdata[tpg_pkg::HIGH_PINS-1:0] ==
			$past(pin_sync[tpg_pkg::NPINS-1:tpg_pkg::LOW_PINS]);
	endproperty
	a_read_level: assert property (p_read_level) else $error("read level mismatch");

	property p_push_pull;
		!st_r.cfg.pin_function_select[0] && st_r.cfg.pin_direction[0] &&
			st_r.cfg.output_drive_type[0] |=>
			st_r.pin_oe[0] && st_r.pin_out[0] == $past(st_r.cfg.pin_level_value[0]);
	endproperty
	a_push_pull: assert property (p_push_pull) else $error("push-pull drive wrong");

	property p_gpio_input;
		!st_r.cfg.pin_function_select[5] && !st_r.cfg.pin_direction[5] |=> !st_r.pin_oe[5];
	endproperty
	a_gpio_input: assert property (p_gpio_input) else $error("input pin driven");

	property p_wake_gate;
		!wake_enable[2] || st_r.cfg.pin_direction[2] |=> !st_r.wake[2];
	endproperty
	a_wake_gate: assert property (p_wake_gate) else $error("wake without enable");

	property p_restore;
		restore && !image_load |=> st_r.cfg == $past(st_r.img);
	endproperty
	a_restore: assert property (p_restore) else $error("image not restored");

	property p_protect;
		(usb_reset || lite_soft_reset) && reset_protect && !image_load &&
			!wr_low && !wr_high |=> $stable(st_r.cfg);
	endproperty
	a_protect: assert property (p_protect) else $error("protected field changed");

	property p_fallback;
		image_load && !eeprom_present && !otp_programmed |=>
			st_r.img == tpg_pkg::CFG_FALLBACK;
	endproperty
	a_fallback: assert property (p_fallback) else $error("fallback not taken");

	property p_eeprom;
		image_load && eeprom_present |=> st_r.img == $past(eeprom_image);
	endproperty
	a_eeprom: assert property (p_eeprom) else $error("eeprom image not taken");

	property p_otp;
		image_load && !eeprom_present && otp_programmed |=> st_r.img == $past(otp_image);
	endproperty
	a_otp: assert property (p_otp) else $error("one-time image not taken");

	property p_protect_load;
		image_load && reset_protect && !wr_low && !wr_high |=> $stable(st_r.cfg);
	endproperty
	a_protect_load: assert property (p_protect_load) else $error("load not blocked");

	property p_open_drain;
		!st_r.cfg.pin_function_select[7] && st_r.cfg.pin_direction[7] &&
			!st_r.cfg.output_drive_type[7] |=>
			!st_r.pin_out[7] && st_r.pin_oe[7] == !$past(st_r.cfg.pin_level_value[7]);
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open-drain drive wrong");

	property p_alt_drive;
		st_r.cfg.pin_function_select[9] |=>
			st_r.pin_oe[9] == $past(alt_oe[9]) && st_r.pin_out[9] == $past(alt_out[9]);
	endproperty
	a_alt_drive: assert property (p_alt_drive) else $error("alternate drive wrong");

	property p_wake_set;
		!st_r.cfg.pin_function_select[10] && !st_r.cfg.pin_direction[10] &&
			wake_enable[10] && pin_sync[10] == wake_polarity[10] |=> st_r.wake[10];
	endproperty
	a_wake_set: assert property (p_wake_set) else $error("wake not raised");

	property p_low_level;
		setup_ph && !apb_req.pwrite && hit_low |=>
			st_r.rsp.prdata[tpg_pkg::LOW_PINS-1:0] == $past(pin_sync[tpg_pkg::LOW_PINS-1:0]);
	endproperty
	a_low_level: assert property (p_low_level) else $error("low level mismatch");

	property p_unmapped;
		setup_ph && !hit_low && !hit_high |=> st_r.rsp.pready && st_r.rsp.pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

	property p_ready_pulse;
		st_r.rsp.pready |=> !st_r.rsp.pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	c_write_low: cover property (wr_low);
	c_read_high: cover property (acc_done && !apb_req.pwrite && hit_high);
	c_restore: cover property (restore ##1 st_r.cfg != tpg_pkg::CFG_FALLBACK);
	c_wake: cover property (st_r.wake != '0);
	c_unmapped: cover property (st_r.rsp.pslverr);
endmodule : tpg_gpio

// ==== dv/tpg_board_model.sv ====
// Board model for the twelve general-purpose pads.
// Assumes the block drives pads through pin_out and pin_oe.
`timescale 1ns/1ps
module tpg_board_model (
	input wire logic [tpg_pkg::NPINS-1:0] pin_out,
	input wire logic [tpg_pkg::NPINS-1:0] pin_oe,
	input wire logic [tpg_pkg::NPINS-1:0] ext_level,
	output logic [tpg_pkg::NPINS-1:0] pin_in
);
	// Block drive wins, else board level
	always_comb begin
		for (int i = 0; i < tpg_pkg::NPINS; i++) begin
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
		end
	end
endmodule : tpg_board_model

// ==== dv/test_twelve_pin_gpio_config.sv ====
// Self-checking bench for the twelve pin configuration block.
// Assumes the APB slave, image loader pins and the board model.
`timescale 1ns/1ps
module test_twelve_pin_gpio_config;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	tpg_pkg::tpg_apb_req_t req = '0;
	tpg_pkg::tpg_apb_rsp_t rsp;
	logic image_load = 1'b0;
	logic usb_reset = 1'b0;
	logic lite_soft_reset = 1'b0;
	logic reset_protect = 1'b0;
	logic eeprom_present = 1'b0;
	logic otp_programmed = 1'b0;
	tpg_pkg::tpg_cfg_t eeprom_image = '0;
	tpg_pkg::tpg_cfg_t otp_image = '0;
	tpg_pkg::tpg_cfg_t cfg;
	tpg_pkg::tpg_cfg_t img;
	logic [11:0] wake_enable = '0;
	logic [11:0] wake_polarity = '0;
	logic [11:0] alt_out = '0;
	logic [11:0] alt_oe = '0;
	logic [11:0] ext_level = '0;
	logic [11:0] pin_in;
	logic [11:0] pin_out;
	logic [11:0] pin_oe;
	logic [11:0] wake_event;
	integer seed = 32'h528C;
	int error_cnt = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic [31:0] d;
	logic err;
	logic [63:0] r64;

	// ----------------------------------------------------------------
	// Clock, design and board
	// ----------------------------------------------------------------
	always #2.5 pclk = ~pclk;

	tpg_gpio tpg_gpio_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.image_load(image_load), .eeprom_present(eeprom_present),
		.otp_programmed(otp_programmed), .eeprom_image(eeprom_image),
		.otp_image(otp_image), .usb_reset(usb_reset), .lite_soft_reset(lite_soft_reset),
		.reset_protect(reset_protect), .wake_enable(wake_enable),
		.wake_polarity(wake_polarity), .alt_out(alt_out), .alt_oe(alt_oe),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .wake_event(wake_event));

	tpg_board_model tpg_board_model_i (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_level(ext_level), .pin_in(pin_in));

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	// Returns {oe, out} per pin
	function automatic logic [23:0] drive_f(tpg_pkg::tpg_cfg_t c);
		logic [23:0] e;
		for (int i = 0; i < 12; i++) begin
			if (c.pin_function_select[i]) begin
				e[12+i] = alt_oe[i];
				e[i] = alt_out[i];
			end else if (c.pin_direction[i]) begin
				e[12+i] = c.output_drive_type[i] | ~c.pin_level_value[i];
				e[i] = c.output_drive_type[i] & c.pin_level_value[i];
			end else begin
				e[12+i] = 1'b0;
				e[i] = 1'b0;
			end
		end
		return e;
	endfunction : drive_f

	function automatic logic [31:0] rd_f(tpg_pkg::tpg_cfg_t c, logic hi, logic [11:0] p);
		if (hi) begin
			return {c.pin_function_select[11:4], c.output_drive_type[11:4],
				c.pin_direction[11:4], p[11:4]};
		end
		return {16'h0000, c.pin_function_select[3:0], c.output_drive_type[3:0],
			c.pin_direction[3:0], p[3:0]};
	endfunction : rd_f

	function automatic tpg_pkg::tpg_cfg_t wr_f(tpg_pkg::tpg_cfg_t c, logic hi, logic [31:0] v);
		if (hi) begin
			c.pin_function_select[11:4] = v[31:24];
			c.output_drive_type[11:4] = v[23:16];
			c.pin_direction[11:4] = v[15:8];
			c.pin_level_value[11:4] = v[7:0];
		end else begin
			c.pin_function_select[3:0] = v[15:12];
			c.output_drive_type[3:0] = v[11:8];
			c.pin_direction[3:0] = v[7:4];
			c.pin_level_value[3:0] = v[3:0];
		end
		return c;
	endfunction : wr_f

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: v};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		if (rsp.pready !== 1'b1) begin
			error_cnt++;
			$display("CHECK FAILED %0t no ready from slave", $time);
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask : apb

	task automatic strobe(input int k);
		@(posedge pclk);
		case (k)
			0: image_load <= 1'b1;
			1: usb_reset <= 1'b1;
			default: lite_soft_reset <= 1'b1;
		endcase
		@(posedge pclk);
		{image_load, usb_reset, lite_soft_reset} <= 3'b000;
	endtask : strobe

	task automatic check_all();
		logic [23:0] e;
		logic [11:0] p;
		repeat (5) @(posedge pclk);
		e = drive_f(cfg);
		p = (e[23:12] & e[11:0]) | (~e[23:12] & ext_level);
		@(negedge pclk);
		chk({20'h0, pin_oe}, {20'h0, e[23:12]});
		chk({20'h0, pin_out & pin_oe}, {20'h0, e[11:0] & e[23:12]});
		chk({20'h0, wake_event}, {20'h0, wake_enable & ~cfg.pin_function_select &
			~cfg.pin_direction & ~(p ^ wake_polarity)});
		apb(1'b0, tpg_pkg::GPIO_LOW_CONFIG_ADDR, 32'h0);
		chk(rd, rd_f(cfg, 1'b0, p));
		apb(1'b0, tpg_pkg::GPIO_HIGH_CONFIG_ADDR, 32'h0);
		chk(rd, rd_f(cfg, 1'b1, p));
	endtask : check_all

	task automatic new_image();
		r64 = {$random(seed), $random(seed)};
		eeprom_image <= r64[47:0];
		img = r64[47:0];
	endtask : new_image

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		cfg = tpg_pkg::CFG_FALLBACK;
		check_all();
		$display("test reset done");
		for (int k = 0; k < 24; k++) begin
			@(posedge pclk);
			ext_level <= 12'($random(seed));
			alt_out <= 12'($random(seed));
			alt_oe <= 12'($random(seed));
			wake_enable <= 12'($random(seed));
			wake_polarity <= 12'($random(seed));
			d = (k < 2) ? 32'hFFFFFFFF : $random(seed);
			apb(1'b1, k[0] ? tpg_pkg::GPIO_HIGH_CONFIG_ADDR : tpg_pkg::GPIO_LOW_CONFIG_ADDR, d);
			cfg = wr_f(cfg, k[0], d);
			check_all();
		end
		$display("test random writes done");
		apb(1'b1, 12'h020, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, 12'h020, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		check_all();
		$display("test unmapped done");
		for (int m = 0; m < 3; m++) begin
			new_image();
			r64 = {$random(seed), $random(seed)};
			otp_image <= r64[47:0];
			eeprom_present <= (m == 0);
			otp_programmed <= (m != 2);
			img = (m == 0) ? img : (m == 1) ? r64[47:0] : tpg_pkg::CFG_FALLBACK;
			strobe(0);
			cfg = img;
			check_all();
			apb(1'b1, tpg_pkg::GPIO_LOW_CONFIG_ADDR, $random(seed));
			strobe(2);
			check_all();
			apb(1'b1, tpg_pkg::GPIO_HIGH_CONFIG_ADDR, $random(seed));
			strobe(1);
			check_all();
		end
		$display("test image done");
		@(posedge pclk);
		reset_protect <= 1'b1;
		d = $random(seed);
		apb(1'b1, tpg_pkg::GPIO_LOW_CONFIG_ADDR, d);
		cfg = wr_f(cfg, 1'b0, d);
		strobe(2);
		check_all();
		eeprom_present <= 1'b1;
		new_image();
		strobe(0);
		check_all();
		@(posedge pclk);
		reset_protect <= 1'b0;
		strobe(1);
		cfg = img;
		check_all();
		$display("test protect done");
		end_sim();
	end

	initial begin
		#100000;
		error_cnt++;
		end_sim();
	end
endmodule : test_twelve_pin_gpio_config
